// ==== src/vof_ctrl.sv ====
/*
 Input over-voltage fault supervision and response with the
 over-temperature warning threshold.
 Assumes a bus engine on the same clock delivers command strobes,
 and measurements, pwm_tick and ramp length are synchronous.
*/
// Behaviour
// - Hold 16-bit temperature warning threshold, 0-160 C.
// - Threshold 255 C disables temperature warning.
// - Hold 16-bit input over-voltage threshold, 4-20 V.
// - Any response: alert low, fault bit set.
// - Code 00 keeps regulating through the fault.
// - Code 01 runs for delay, then retry.
// - Code 10 disables output now, then retry.
// - Retry 000 latches off until fault cleared.
// - Retry 1-6 attempts, then off until reset.
// - Retry 111 retries until output disabled.
// - Restart spacing from delay field and unit.
// - Delay 0: one period, hiccup one ramp.
// - Codes 1-7: 1,3,3,3,7,7,7 periods, hiccup code*ramp.
`timescale 1ns/1ps
`include "vof_map.svh"
module vof_ctrl (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire vof_pkg::vof_cmd_s cmd,
	input wire logic pwm_tick,
	input wire logic [15:0] vin_meas,
	input wire logic [15:0] temp_meas,
	input wire logic [15:0] turn_on_ramp_time,
	input wire logic run_req,
	input wire logic fault_clear,
	output logic [15:0] rd_data,
	output logic out_enable,
	output logic fault_alert_line_n,
	output vof_pkg::vof_stat_s stat
);
	import vof_pkg::*;

	// Register file
	logic [15:0] temp_thr_reg, temp_thr_next; // Temperature warning threshold
	logic [15:0] ov_thr_reg, ov_thr_next; // Input over-voltage threshold
	logic [7:0] act_reg, act_next; // Fault action setting
	logic [15:0] rd_data_next; // Read answer
	// Field views
	logic [1:0] resp; // Response code
	logic [2:0] retry; // Retry setting
	logic [2:0] dcode; // Delay code

	// Register writes and reads
	always_comb begin
		temp_thr_next = temp_thr_reg;
		ov_thr_next = ov_thr_reg;
		act_next = act_reg;
		rd_data_next = rd_data;
		if (cmd.valid && cmd.write) begin
			unique case (cmd.code)
				`VOF_ADDR_TEMP: temp_thr_next = cmd.data;
				`VOF_ADDR_OVTH: ov_thr_next = cmd.data;
				`VOF_ADDR_ACT: act_next = cmd.data[7:0];
				default: ;
			endcase
		end else if (cmd.valid) begin
			unique case (cmd.code)
				`VOF_ADDR_TEMP: rd_data_next = temp_thr_reg;
				`VOF_ADDR_OVTH: rd_data_next = ov_thr_reg;
				`VOF_ADDR_ACT: rd_data_next = {8'h00, act_reg};
				default: rd_data_next = 16'h0000; // Unknown code reads zero
			endcase
		end
	end

	// Register storage
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			temp_thr_reg <= `VOF_RST_TEMP;
			ov_thr_reg <= `VOF_RST_OVTH;
			act_reg <= `VOF_RST_ACT;
			rd_data <= 16'h0000;
		end else if (clk_en) begin
			temp_thr_reg <= temp_thr_next;
			ov_thr_reg <= ov_thr_next;
			act_reg <= act_next;
			rd_data <= rd_data_next;
		end
	end

	assign resp = act_reg[`VOF_RESP_HI:`VOF_RESP_LO];
	assign retry = act_reg[`VOF_RETRY_HI:`VOF_RETRY_LO];
	assign dcode = act_reg[`VOF_DLY_HI:`VOF_DLY_LO];

	// Fault detection and sticky flags
	logic ov_reg, ov_next; // Registered over-voltage compare
	logic ot_reg, ot_next; // Registered temperature compare
	logic ov_flag_reg, ov_flag_next; // Sticky fault bit
	logic ot_flag_reg, ot_flag_next; // Sticky warning bit
	logic alert_n_next; // Alert line level

	// Compares and flags; a set beats a clear
	always_comb begin
		ov_next = vin_meas > ov_thr_reg;
		ot_next = (temp_thr_reg != `VOF_TEMP_OFF) && (temp_meas > temp_thr_reg);
		ov_flag_next = ov_flag_reg;
		ot_flag_next = ot_flag_reg;
		if (fault_clear) begin
			ov_flag_next = 1'b0;
			ot_flag_next = 1'b0;
		end
		if (ov_reg) begin
			ov_flag_next = 1'b1;
		end
		if (ot_reg) begin
			ot_flag_next = 1'b1;
		end
		alert_n_next = !(ov_flag_next || ot_flag_next);
	end

	// Detection storage
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ov_reg <= 1'b0;
			ot_reg <= 1'b0;
			ov_flag_reg <= 1'b0;
			ot_flag_reg <= 1'b0;
			fault_alert_line_n <= 1'b1;
		end else if (clk_en) begin
			ov_reg <= ov_next;
			ot_reg <= ot_next;
			ov_flag_reg <= ov_flag_next;
			ot_flag_reg <= ot_flag_next;
			fault_alert_line_n <= alert_n_next;
		end
	end

	// Response sequencer
	vof_state_e state_reg, state_next; // Response state
	logic [2:0] sd_reg, sd_next; // Shutdown delay left, switching periods
	logic [18:0] hic_reg, hic_next; // Hiccup cycles left
	logic [2:0] tries_reg, tries_next; // Failed attempts so far
	logic out_en_next; // Output enable
	logic [2:0] sd_load; // Shutdown delay for the delay code
	logic [18:0] hic_load; // Hiccup length in cycles
	logic [2:0] hic_mult; // Ramp multiples per hiccup
	logic [3:0] tries_inc; // Attempts after this failure

	// Table of delays
	always_comb begin
		if (dcode < `VOF_DCODE_SD3) begin
			sd_load = `VOF_SD_ONE;
		end else if (dcode < `VOF_DCODE_SD7) begin
			sd_load = `VOF_SD_THREE;
		end else begin
			sd_load = `VOF_SD_SEVEN;
		end
		hic_mult = (dcode == 3'h0) ? 3'h1 : dcode;
		hic_load = 19'(turn_on_ramp_time * hic_mult);
		if (hic_load == 19'h00000) begin
			hic_load = 19'h00001;
		end
		tries_inc = {1'b0, tries_reg} + 4'h1;
	end

	// Next state
	always_comb begin
		state_next = state_reg;
		sd_next = sd_reg;
		hic_next = hic_reg;
		tries_next = tries_reg;
		unique case (state_reg)
			VOF_RUN: begin
				// Code 00 never leaves this state
				if (ov_reg && run_req && resp != `VOF_RESP_IGNORE) begin
					if (resp == `VOF_RESP_DELAY) begin
						state_next = VOF_HOLD;
						sd_next = sd_load;
					end else if (retry == `VOF_RETRY_LATCH) begin
						state_next = VOF_LATCH;
					end else begin
						state_next = VOF_WAIT;
						hic_next = hic_load;
					end
				end
			end
			VOF_HOLD: begin
				// Still running while the delay runs out
				if (!ov_reg) begin
					state_next = VOF_RUN;
				end else if (pwm_tick && sd_reg <= 3'h1) begin
					if (retry == `VOF_RETRY_LATCH) begin
						state_next = VOF_LATCH;
					end else begin
						state_next = VOF_WAIT;
						hic_next = hic_load;
					end
				end else if (pwm_tick) begin
					sd_next = sd_reg - 3'h1;
				end
			end
			VOF_WAIT: begin
				// Output off, hiccup before next attempt
				if (retry == `VOF_RETRY_FOREVER && !run_req) begin
					state_next = VOF_RUN;
					tries_next = 3'h0;
				end else if (hic_reg > 19'h00001) begin
					hic_next = hic_reg - 19'h00001;
				end else if (!ov_reg) begin
					state_next = VOF_RUN;
					tries_next = 3'h0;
				end else if (retry != `VOF_RETRY_FOREVER && tries_inc >= {1'b0, retry}) begin
					state_next = VOF_LOCK;
				end else begin
					hic_next = hic_load;
					tries_next = (retry == `VOF_RETRY_FOREVER) ? tries_reg : tries_inc[2:0];
				end
			end
			VOF_LATCH: begin
				// Off until the fault is cleared
				if (fault_clear) begin
					state_next = VOF_RUN;
				end
			end
			VOF_LOCK: begin
				// Off until reset
				state_next = VOF_LOCK;
			end
		endcase
		if (fault_clear) begin
			tries_next = 3'h0;
		end
		out_en_next = run_req && (state_next == VOF_RUN || state_next == VOF_HOLD);
	end

	// Sequencer storage
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= VOF_RUN;
			sd_reg <= 3'h0;
			hic_reg <= 19'h00000;
			tries_reg <= 3'h0;
			out_enable <= 1'b0;
			stat <= '0;
		end else if (clk_en) begin
			state_reg <= state_next;
			sd_reg <= sd_next;
			hic_reg <= hic_next;
			tries_reg <= tries_next;
			out_enable <= out_en_next;
			stat <= {ov_flag_next, ot_flag_next, state_next == VOF_LOCK};
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_run_fault_disable;
		state_reg == VOF_RUN && ov_reg && run_req && clk_en && resp == 2'h2;
	endsequence
	sequence s_attempt_fail;
		state_reg == VOF_WAIT && hic_reg == 19'h00001 && ov_reg && clk_en && run_req;
	endsequence

	a_ignore_keeps_running: assert property (
		state_reg == VOF_RUN && resp == `VOF_RESP_IGNORE |=> state_reg == VOF_RUN)
		else $error("ignore response left running state");
	a_disable_output_now: assert property (
		s_run_fault_disable |=> !out_enable && state_reg != VOF_RUN)
		else $error("disable response did not drop output");
	a_flag_drives_alert: assert property (
		ov_reg && clk_en |=> ov_flag_reg && !fault_alert_line_n && stat.vin_ov_fault)
		else $error("fault did not raise flag and alert");
	a_temp_warn_off: assert property (
		temp_thr_reg == `VOF_TEMP_OFF && clk_en |=> !ot_reg)
		else $error("disabled temperature warning fired");
	a_latch_stays_off: assert property (
		state_reg == VOF_LATCH && !fault_clear |=> state_reg == VOF_LATCH && !out_enable)
		else $error("latched state left without clear");
	a_lock_stays_off: assert property (
		state_reg == VOF_LOCK |=> state_reg == VOF_LOCK && !out_enable && stat.locked)
		else $error("locked state left before reset");
	a_fail_counts: assert property (
		s_attempt_fail ##0 (retry != `VOF_RETRY_FOREVER && !fault_clear)
		|=> state_reg == VOF_LOCK || tries_reg == $past(tries_reg) + 3'h1)
		else $error("failed attempt not counted");
	a_hold_delay_len: assert property (
		state_reg == VOF_RUN ##1 state_reg == VOF_HOLD |-> sd_reg == $past(sd_load))
		else $error("shutdown delay loaded wrong");
	a_hiccup_spacing: assert property (
		state_reg != VOF_WAIT ##1 state_reg == VOF_WAIT |-> hic_reg == $past(hic_load))
		else $error("hiccup interval loaded wrong");
	a_forever_no_lock: assert property (
		state_reg == VOF_WAIT && retry == `VOF_RETRY_FOREVER && clk_en |=> state_reg != VOF_LOCK)
		else $error("continuous retry locked off");
	a_wait_output_off: assert property (
		state_reg == VOF_WAIT |-> !out_enable)
		else $error("output on during hiccup wait");
	a_hold_keeps_output: assert property (
		state_reg == VOF_HOLD && run_req && clk_en && !pwm_tick |=> out_enable)
		else $error("output dropped before delay ran out");
	a_clear_resets_count: assert property (
		fault_clear && clk_en |=> tries_reg == 3'h0)
		else $error("clear did not reset attempt count");
endmodule

// ==== src/vof_map.svh ====
/*
 Register offsets, field positions, codes and reset values of the
 input over-voltage fault response block.
 Assumes inclusion by the design module only.
*/
`ifndef VOF_MAP_SVH
`define VOF_MAP_SVH
// Command codes of the three registers
`define VOF_ADDR_TEMP 8'h51
`define VOF_ADDR_OVTH 8'h55
`define VOF_ADDR_ACT 8'h56
// Reset values
`define VOF_RST_TEMP 16'h0064
`define VOF_RST_OVTH 16'h0010
`define VOF_RST_ACT 8'h80
// Field positions in the action register
`define VOF_RESP_HI 7
`define VOF_RESP_LO 6
`define VOF_RETRY_HI 5
`define VOF_RETRY_LO 3
`define VOF_DLY_HI 2
`define VOF_DLY_LO 0
// Response codes
`define VOF_RESP_IGNORE 2'h0
`define VOF_RESP_DELAY 2'h1
// Retry codes
`define VOF_RETRY_LATCH 3'h0
`define VOF_RETRY_FOREVER 3'h7
// Threshold value that turns the temperature warning off
`define VOF_TEMP_OFF 16'h00FF
// Shutdown delays in switching periods
`define VOF_SD_ONE 3'h1
`define VOF_SD_THREE 3'h3
`define VOF_SD_SEVEN 3'h7
// Delay code boundaries of the shutdown delay table
`define VOF_DCODE_SD3 3'h2
`define VOF_DCODE_SD7 3'h5
`endif

// ==== src/vof_pkg.sv ====
/*
 Types of the input over-voltage fault response block.
 Assumes the constants header is on the include path.
*/
package vof_pkg;
	// Command from the bus engine
	typedef struct packed {
		logic valid; // One-cycle strobe
		logic write; // High for write
		logic [7:0] code; // Command code
		logic [15:0] data; // Write data
	} vof_cmd_s;
	// Status flags to the status registers
	typedef struct packed {
		logic vin_ov_fault; // Sticky input over-voltage fault
		logic temp_warn; // Sticky over-temperature warning
		logic locked; // Retries exhausted
	} vof_stat_s;
	// Fault response states, one-hot
	typedef enum logic [4:0] {
		VOF_RUN = 5'h01,
		VOF_HOLD = 5'h02,
		VOF_WAIT = 5'h04,
		VOF_LATCH = 5'h08,
		VOF_LOCK = 5'h10
	} vof_state_e;
endpackage

// ==== test/vof_host.sv ====
/*
 Host model of the register side: issues write and read commands.
 Assumes the bench calls its tasks and the clock runs freely.
*/
`timescale 1ns/1ps
module vof_host (
	input wire logic clock,
	input wire logic [15:0] rd_data,
	output vof_pkg::vof_cmd_s cmd
);
	import vof_pkg::*;
	// Bus idle at start
	initial begin
		cmd = '0;
	end
	// One strobe, launched and dropped off the falling edge
	task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] data);
		@(negedge clock);
		cmd = '{valid: 1'b1, write: wr, code: code, data: data};
		@(negedge clock);
		// Released: stale fields inverted so nothing relies on them
		cmd = '{valid: 1'b0, write: ~wr, code: ~code, data: ~data};
	endtask
	// Read answer is held once the take edge has passed
	task automatic rd(input logic [7:0] code, output logic [15:0] val);
		issue(1'b0, code, 16'h0000);
		val = rd_data;
	endtask
endmodule

// ==== test/tb_top.sv ====
/*
 Self-checking bench of the over-voltage fault response block.
 Assumes the host model drives the command port.
*/
`timescale 1ns/1ps
module tb_top;
	import vof_pkg::*;
	typedef struct {logic [7:0] c; logic [15:0] w; logic [15:0] e;} vof_row_s;
	logic clock, rst_n, clk_en, run_req, fault_clear;
	logic pwm_tick = 1'b0; // Switching tick, high one cycle in two
	logic [15:0] vin_meas, temp_meas, ramp, rd_data, val;
	logic out_enable, alert_n;
	vof_cmd_s cmd;
	vof_stat_s stat;
	int fail_count = 0;
	int n_checks = 0;
	// Register rows: code, written value, expected read
	vof_row_s rows [5] = '{'{8'h51, 16'h00A0, 16'h00A0}, '{8'h55, 16'h0014, 16'h0014},
		'{8'h56, 16'hFFC3, 16'h00C3}, '{8'h57, 16'h1234, 16'h0000}, '{8'h51, 16'h00FF, 16'h00FF}};
	vof_ctrl u_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .cmd(cmd), .pwm_tick(pwm_tick),
		.vin_meas(vin_meas), .temp_meas(temp_meas), .turn_on_ramp_time(ramp), .run_req(run_req),
		.fault_clear(fault_clear), .rd_data(rd_data), .out_enable(out_enable),
		.fault_alert_line_n(alert_n), .stat(stat));
	vof_host u_host (.clock(clock), .rd_data(rd_data), .cmd(cmd));
	// Clock, 25 ns period
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Switching tick every second cycle
	always @(negedge clock) begin
		pwm_tick <= ~pwm_tick;
	end
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Clear pulse once the compare has dropped, so a set cannot win over it
	task automatic clr;
		cyc(2);
		fault_clear = 1'b1;
		cyc(1);
		fault_clear = 1'b0;
		cyc(3);
	endtask
	task automatic final_report;
		if (fail_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog well beyond the sequence length
	initial begin
		repeat (3000) @(posedge clock);
		fail_count++;
		final_report;
	end
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		run_req = 1'b1;
		fault_clear = 1'b0;
		vin_meas = 16'h000C;
		temp_meas = 16'h0019;
		ramp = 16'h0004;
		cyc(7);
		rst_n = 1'b1;
		cyc(2);
		// Register table
		foreach (rows[i]) begin
			u_host.issue(1'b1, rows[i].c, rows[i].w);
			u_host.rd(rows[i].c, val);
			check("register", val, rows[i].e);
		end
		// Warning off at 255 even when hotter, then on
		temp_meas = 16'h0100;
		cyc(4);
		check("temp_warn off", stat.temp_warn, 1'b0);
		u_host.issue(1'b1, 8'h51, 16'h00A0);
		cyc(4);
		check("temp_warn", stat.temp_warn, 1'b1);
		temp_meas = 16'h0019;
		clr;
		// Ignore: equal is no fault, above faults but keeps running
		u_host.issue(1'b1, 8'h56, 16'h0000);
		vin_meas = 16'h0014;
		cyc(4);
		check("ov at limit", stat.vin_ov_fault, 1'b0);
		vin_meas = 16'h0015;
		cyc(4);
		check("ov flag", stat.vin_ov_fault, 1'b1);
		check("alert", alert_n, 1'b0);
		check("out ignore", out_enable, 1'b1);
		vin_meas = 16'h000C;
		clr;
		// Disable, latch off until cleared
		u_host.issue(1'b1, 8'h56, 16'h0080);
		vin_meas = 16'h0015;
		cyc(3);
		check("out disable", out_enable, 1'b0);
		vin_meas = 16'h000C;
		cyc(20);
		check("out latched", out_enable, 1'b0);
		clr;
		check("out cleared", out_enable, 1'b1);
		// Disable, one retry, fault stays
		u_host.issue(1'b1, 8'h56, 16'h0088);
		vin_meas = 16'h0015;
		cyc(12);
		check("locked", stat.locked, 1'b1);
		vin_meas = 16'h000C;
		clr;
		cyc(10);
		check("out locked", out_enable, 1'b0);
		// Second reset restores defaults
		rst_n = 1'b0;
		cyc(2);
		check("reset out", out_enable, 1'b0);
		check("reset alert", alert_n, 1'b1);
		check("reset stat", stat, 3'h0);
		rst_n = 1'b1;
		u_host.rd(8'h51, val);
		check("temp reset", val, 16'h0064);
		u_host.rd(8'h55, val);
		check("ov reset", val, 16'h0010);
		u_host.rd(8'h56, val);
		check("act reset", val, 16'h0080);
		// Run for seven ticks, then retry forever every 5 ramps
		u_host.issue(1'b1, 8'h56, 16'h007D);
		vin_meas = 16'h0011;
		cyc(11);
		check("out in delay", out_enable, 1'b1);
		cyc(8);
		check("out after delay", out_enable, 1'b0);
		cyc(40);
		check("out retrying", out_enable, 1'b0);
		check("never locks", stat.locked, 1'b0);
		vin_meas = 16'h000C;
		cyc(8);
		check("hiccup spacing", out_enable, 1'b0);
		cyc(14);
		check("restart", out_enable, 1'b1);
		// Clock enable low: a write is lost and the read answer stays put
		clk_en = 1'b0;
		u_host.issue(1'b1, 8'h51, 16'h0033);
		u_host.rd(8'h51, val);
		check("frozen read", val, 16'h0080);
		clk_en = 1'b1;
		u_host.rd(8'h51, val);
		check("frozen write", val, 16'h0064);
		final_report;
	end
endmodule
